// ==== hdl/dpr_regmap.sv ====
`timescale 1ns/100ps
module dpr_regmap
   import dpr_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // link pins, asynchronous to clock
   input  wire logic        link_clk,
   input  wire logic        lk_valid,
   input  wire logic        lk_is_ap,
   input  wire logic        lk_rnw,
   input  wire logic [1:0]  lk_addr,
   input  wire logic [31:0] lk_wdata,
   input  wire logic        lk_abort_ir,
   // straps and acknowledges, asynchronous
   input  wire logic        cfg_serial,
   input  wire logic        cfg_arch_v2,
   input  wire logic        cfg_proto_v2,
   input  wire logic        sys_pwr_ack,
   input  wire logic        dbg_pwr_ack,
   input  wire logic        dbg_rst_ack,
   // access port side, same clock
   input  wire logic        ap_rdata_valid,
   input  wire logic [31:0] ap_rdata,
   input  wire logic        ap_resp_ok,
   input  wire logic        ap_done,
   input  wire logic        ap_reg_locked,
   input  wire logic        ap_recovered,
   input  wire logic        evt_ap_error,
   input  wire logic        evt_overrun,
   input  wire logic        evt_wdata_error,
   input  wire logic        evt_cmp_mismatch,
   input  wire logic [31:0] event_status,
   // answer to the link
   output logic             resp_valid,
   output logic             resp_wait,
   output logic [31:0]      resp_rdata,
   // access port requests
   output logic             abort_pulse,
   output logic             ap_req,
   output logic             ap_req_rnw,
   output logic [1:0]       ap_req_addr,
   output logic [31:0]      ap_req_wdata,
   output logic [7:0]       ap_sel,
   // control and status
   output logic             sys_pwr_req,
   output logic             dbg_pwr_req,
   output logic             dbg_rst_req,
   output logic [31:0]      target_sel,
   output logic [31:0]      link_ctrl,
   output logic [11:0]      trn_cnt,
   output logic [3:0]       sticky_flags
);

   dpr_state_s  st_r;      // registered state
   dpr_state_s  st_nxt;    // next state
   dpr_pins_s   pins_now;  // raw pins gathered for the synchroniser
   logic        take;      // a link access is taken this cycle
   logic [3:0]  ofs;       // byte offset of the access
   logic [3:0]  bank;      // held bank select
   logic [7:0]  apsel;     // held port select
   logic        abort_wr;  // this access writes the abort register
   logic [31:0] cs_word;   // control/status as read

   // gather the asynchronous pins into one word
   always_comb begin
      pins_now.lclk     = link_clk;
      pins_now.valid    = lk_valid;
      pins_now.is_ap    = lk_is_ap;
      pins_now.rnw      = lk_rnw;
      pins_now.addr     = lk_addr;
      pins_now.wdata    = lk_wdata;
      pins_now.abort_ir = lk_abort_ir;
      pins_now.serial   = cfg_serial;
      pins_now.arch_v2  = cfg_arch_v2;
      pins_now.proto_v2 = cfg_proto_v2;
      pins_now.sys_ack  = sys_pwr_ack;
      pins_now.dbg_ack  = dbg_pwr_ack;
      pins_now.rst_ack  = dbg_rst_ack;
   end

   // decode helpers; only the second stage is read, never the first
   always_comb begin
      take  = st_r.sync2.lclk & ~st_r.lclk_d & st_r.sync2.valid;
      ofs   = {st_r.sync2.addr, 2'b00};
      bank  = st_r.select[DPR_SEL_BANK_LSB +: 4];
      apsel = st_r.select[DPR_SEL_AP_LSB +: 8];
      // serial link: write at 0x0; scan chain: own instruction only
      abort_wr = take & ~st_r.sync2.is_ap & ~st_r.sync2.rnw
               & (ofs == DPR_OFS_ID_ABORT)
               & (st_r.sync2.serial | st_r.sync2.abort_ir);
   end

   // control/status word as the debugger sees it
   always_comb begin
      cs_word                              = DPR_RST_WORD;
      cs_word[DPR_CS_SYS_ACK]              = st_r.sync2.sys_ack;
      cs_word[DPR_CS_SYS_REQ]              = st_r.sys_req;
      cs_word[DPR_CS_DBG_ACK]              = st_r.sync2.dbg_ack;
      cs_word[DPR_CS_DBG_REQ]              = st_r.dbg_req;
      cs_word[DPR_CS_RST_ACK]              = st_r.sync2.rst_ack;
      cs_word[DPR_CS_RST_REQ]              = st_r.rst_req;
      cs_word[DPR_CS_TRN_LSB +: 12]        = st_r.trn_cnt;
      cs_word[DPR_CS_MASK_LSB +: 4]        = st_r.mask_lane;
      cs_word[DPR_CS_WDERR]                = st_r.wdata_err;
      // read-ok has meaning on the serial link only
      cs_word[DPR_CS_READOK]               = st_r.read_ok & st_r.sync2.serial;
      cs_word[DPR_CS_STKERR]               = st_r.sticky_err;
      cs_word[DPR_CS_STKCMP]               = st_r.sticky_cmp;
      cs_word[DPR_CS_MODE_LSB +: 2]        = st_r.trn_mode;
      cs_word[DPR_CS_STKORUN]              = st_r.sticky_orun;
      cs_word[DPR_CS_ORUNDET]              = st_r.orun_det;
   end

   // next-state logic: synchroniser, decode, flags, answer
   always_comb begin
      st_nxt             = st_r;
      st_nxt.sync1       = pins_now;
      st_nxt.sync2       = st_r.sync1;
      st_nxt.lclk_d      = st_r.sync2.lclk;
      // one-cycle pulses fall back by default
      st_nxt.resp_valid  = 1'b0;
      st_nxt.resp_wait   = 1'b0;
      st_nxt.abort_pulse = 1'b0;
      st_nxt.ap_req      = 1'b0;

      // counter counts finished port transactions down
      if (ap_done && st_r.trn_cnt != 12'h000) begin
         st_nxt.trn_cnt = st_r.trn_cnt - 12'h001;
      end

      // read buffer follows port read results
      if (ap_rdata_valid) begin
         st_nxt.read_buffer_reg  = ap_rdata;
         st_nxt.read_ok = ap_resp_ok;
      end

      // the aborted port regains access when it reports recovery
      if (ap_recovered) begin
         st_nxt.aborted = 1'b0;
      end

      // link-side access decode
      if (take) begin
         st_nxt.resp_valid = 1'b1;
         st_nxt.rdata      = DPR_RST_WORD;
         if (st_r.sync2.is_ap) begin
            if (st_r.aborted && apsel == st_r.aborted_ap && ap_reg_locked) begin
               st_nxt.resp_wait = 1'b1;
            end else if (st_r.aborted) begin
               // accepted, read as zero, nothing forwarded
               st_nxt.rdata = DPR_RST_WORD;
            end else begin
               st_nxt.ap_req   = 1'b1;
               st_nxt.ap_rnw   = st_r.sync2.rnw;
               st_nxt.ap_addr  = st_r.sync2.addr;
               st_nxt.ap_wdata = st_r.sync2.wdata;
               st_nxt.rdata    = st_r.read_buffer_reg;
            end
         end else if (st_r.sync2.rnw) begin
            // reads: different registers than writes at most offsets
            case (ofs)
               DPR_OFS_ID_ABORT: begin
                  // abort content never returned
                  st_nxt.rdata = DPR_PORT_ID;
               end
               DPR_OFS_CTRL_BANK: begin
                  case (bank)
                     DPR_BANK_CTRL:   st_nxt.rdata = cs_word;
                     DPR_BANK_LINK:   st_nxt.rdata = st_r.link_ctrl;
                     // banks above 1 are undefined in version 1
                     DPR_BANK_TGTID:  st_nxt.rdata = st_r.sync2.arch_v2 ?
                                                     DPR_TARGET_ID : DPR_RST_WORD;
                     DPR_BANK_PROTID: st_nxt.rdata = st_r.sync2.arch_v2 ?
                                                     DPR_PROTO_ID : DPR_RST_WORD;
                     DPR_BANK_EVENT:  st_nxt.rdata = st_r.sync2.arch_v2 ?
                                                     event_status : DPR_RST_WORD;
                     default:         st_nxt.rdata = DPR_RST_WORD;
                  endcase
               end
               DPR_OFS_SEL_RETRY: begin
                  // selector is write-only; scan chain slot reads zero
                  st_nxt.rdata = st_r.sync2.serial ? st_r.retry : DPR_RST_WORD;
               end
               default: begin
                  st_nxt.rdata = st_r.read_buffer_reg;
               end
            endcase
            if (ofs != DPR_OFS_SEL_RETRY) begin
               st_nxt.retry = st_nxt.rdata;
            end
         end else begin
            // writes
            case (ofs)
               DPR_OFS_ID_ABORT: begin
                  // handled by the abort path below
               end
               DPR_OFS_CTRL_BANK: begin
                  if (bank == DPR_BANK_CTRL) begin
                     st_nxt.sys_req   = st_r.sync2.wdata[DPR_CS_SYS_REQ];
                     st_nxt.dbg_req   = st_r.sync2.wdata[DPR_CS_DBG_REQ];
                     st_nxt.rst_req   = st_r.sync2.wdata[DPR_CS_RST_REQ];
                     st_nxt.trn_cnt   = st_r.sync2.wdata[DPR_CS_TRN_LSB +: 12];
                     st_nxt.mask_lane = st_r.sync2.wdata[DPR_CS_MASK_LSB +: 4];
                     st_nxt.trn_mode  = st_r.sync2.wdata[DPR_CS_MODE_LSB +: 2];
                     st_nxt.orun_det  = st_r.sync2.wdata[DPR_CS_ORUNDET];
                     // scan chain clears flags by write-one; serial ignores
                     if (!st_r.sync2.serial) begin
                        if (st_r.sync2.wdata[DPR_CS_STKERR]) st_nxt.sticky_err = 1'b0;
                        if (st_r.sync2.wdata[DPR_CS_STKCMP]) st_nxt.sticky_cmp = 1'b0;
                        if (st_r.sync2.wdata[DPR_CS_STKORUN]) st_nxt.sticky_orun = 1'b0;
                     end
                  end else if (bank == DPR_BANK_LINK) begin
                     st_nxt.link_ctrl = st_r.sync2.wdata;
                  end
               end
               DPR_OFS_SEL_RETRY: begin
                  st_nxt.select = st_r.sync2.wdata;
               end
               default: begin
                  // target selection on serial protocol version 2 only
                  if (st_r.sync2.serial && st_r.sync2.arch_v2 && st_r.sync2.proto_v2) begin
                     st_nxt.target_sel = st_r.sync2.wdata;
                  end
               end
            endcase
         end
      end

      // abort register effects
      if (abort_wr) begin
         st_nxt.rdata = DPR_RST_WORD;
         if (st_r.sync2.wdata[DPR_AB_ORUN_CLR]) st_nxt.sticky_orun = 1'b0;
         if (st_r.sync2.wdata[DPR_AB_WDE_CLR])  st_nxt.wdata_err   = 1'b0;
         if (st_r.sync2.wdata[DPR_AB_ERR_CLR])  st_nxt.sticky_err  = 1'b0;
         if (st_r.sync2.wdata[DPR_AB_CMP_CLR])  st_nxt.sticky_cmp  = 1'b0;
         // only bit 0 matters for a version 0 style write; other bits are
         // taken as the clears of the later maps, there is no version 0 mode
         if (st_r.sync2.wdata[DPR_AB_TRIG]) begin
            st_nxt.abort_pulse = 1'b1;
            st_nxt.trn_cnt     = 12'h000;
            // any request still queued toward the port is dropped
            st_nxt.ap_req      = 1'b0;
            st_nxt.aborted     = 1'b1;
            st_nxt.aborted_ap  = apsel;
         end
      end

      // hardware sets win over any clear in the same cycle; the abort
      // itself sets nothing and clears nothing it was not asked to
      if (evt_overrun && st_r.orun_det) st_nxt.sticky_orun = 1'b1;
      if (evt_wdata_error)              st_nxt.wdata_err   = 1'b1;
      if (evt_ap_error)                 st_nxt.sticky_err  = 1'b1;
      if (evt_cmp_mismatch)             st_nxt.sticky_cmp  = 1'b1;
   end

   // single state register, synchronous reset to constants
   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign resp_valid   = st_r.resp_valid;
   assign resp_wait    = st_r.resp_wait;
   assign resp_rdata   = st_r.rdata;
   assign abort_pulse  = st_r.abort_pulse;
   assign ap_req       = st_r.ap_req;
   assign ap_req_rnw   = st_r.ap_rnw;
   assign ap_req_addr  = st_r.ap_addr;
   assign ap_req_wdata = st_r.ap_wdata;
   assign ap_sel       = st_r.select[DPR_SEL_AP_LSB +: 8];
   assign sys_pwr_req  = st_r.sys_req;
   assign dbg_pwr_req  = st_r.dbg_req;
   assign dbg_rst_req  = st_r.rst_req;
   assign target_sel   = st_r.target_sel;
   assign link_ctrl    = st_r.link_ctrl;
   assign trn_cnt      = st_r.trn_cnt;
   assign sticky_flags = {st_r.sticky_orun, st_r.wdata_err, st_r.sticky_err, st_r.sticky_cmp};

   // checks on the decode and the abort path
   default clocking dpr_cb @(posedge clock);
   endclocking
   default disable iff (reset);

   logic dp_rd;  // a port-register read taken now
   assign dp_rd = take & ~st_r.sync2.is_ap & st_r.sync2.rnw;

   AST_ID_READ: assert property (dp_rd && ofs == DPR_OFS_ID_ABORT |=>
      resp_valid && resp_rdata == DPR_PORT_ID) else $error("id read wrong");
   AST_BANK_TGT: assert property (dp_rd && ofs == DPR_OFS_CTRL_BANK
      && bank == DPR_BANK_TGTID && st_r.sync2.arch_v2 |=>
      resp_rdata == DPR_TARGET_ID) else $error("bank decode wrong");
   AST_SEL_SCAN: assert property (dp_rd && ofs == DPR_OFS_SEL_RETRY
      && !st_r.sync2.serial |=> resp_rdata == DPR_RST_WORD) else $error("selector read");
   AST_ABORT_PULSE: assert property (abort_wr && st_r.sync2.wdata[DPR_AB_TRIG] |=>
      abort_pulse && trn_cnt == 12'h000 && !ap_req) else $error("abort missed");
   AST_ORUN_CLR: assert property (abort_wr && st_r.sync2.wdata[DPR_AB_ORUN_CLR]
      && !evt_overrun |=> !sticky_flags[3]) else $error("overrun not cleared");
   AST_WDE_CLR: assert property (abort_wr && st_r.sync2.wdata[DPR_AB_WDE_CLR]
      && !evt_wdata_error |=> !sticky_flags[2]) else $error("wdata flag kept");
   AST_ERR_CLR: assert property (abort_wr && st_r.sync2.wdata[DPR_AB_ERR_CLR]
      && !evt_ap_error |=> !sticky_flags[1]) else $error("error flag kept");
   AST_CMP_CLR: assert property (abort_wr && st_r.sync2.wdata[DPR_AB_CMP_CLR]
      && !evt_cmp_mismatch |=> !sticky_flags[0]) else $error("compare flag kept");
   AST_FLAGS_KEPT: assert property (abort_wr && st_r.sync2.wdata[4:1] == 4'h0 |=>
      sticky_flags == $past(sticky_flags) || $past(evt_ap_error)
      || $past(evt_overrun) || $past(evt_wdata_error) || $past(evt_cmp_mismatch))
      else $error("abort touched flags");
   AST_WAIT_LOCKED: assert property (take && st_r.sync2.is_ap && st_r.aborted
      && apsel == st_r.aborted_ap && ap_reg_locked |=> resp_wait ##1 !resp_wait)
      else $error("no wait answer");
   AST_RAZ_AFTER: assert property (take && st_r.sync2.is_ap && st_r.aborted
      && apsel != st_r.aborted_ap |=> resp_valid && !resp_wait && !ap_req
      && resp_rdata == DPR_RST_WORD) else $error("access after abort");

   // nothing reaches the port side while an abort is outstanding
   AST_NO_FWD: assert property (take && st_r.sync2.is_ap && st_r.aborted |=>
      !ap_req) else $error("request forwarded after abort");
   // a bare trigger word still aborts, with no flag clears implied
   AST_TRIG_ONLY: assert property (abort_wr && st_r.sync2.wdata == 32'h0000_0001 |=>
      abort_pulse) else $error("bare trigger ignored");
   // target selection is left alone under protocol version 1
   AST_TSEL_V1: assert property (take && !st_r.sync2.is_ap && !st_r.sync2.rnw
      && ofs == DPR_OFS_RDBUF_TS && !st_r.sync2.proto_v2 |=>
      target_sel == $past(target_sel)) else $error("target selection written");
   // the retry slot gives back the last port-register read, not the selector
   AST_RETRY_RD: assert property (dp_rd && ofs == DPR_OFS_SEL_RETRY
      && st_r.sync2.serial |=> resp_rdata == $past(st_r.retry))
      else $error("retry read wrong");
   // bank 1 writes land in link control through the held bank value
   AST_LINK_WR: assert property (take && !st_r.sync2.is_ap && !st_r.sync2.rnw
      && ofs == DPR_OFS_CTRL_BANK && bank == DPR_BANK_LINK |=>
      link_ctrl == $past(st_r.sync2.wdata)) else $error("link control lost");

   COV_ABORT: cover property (abort_wr ##1 abort_pulse);
   COV_WAIT: cover property (resp_valid && resp_wait);
   COV_TSEL: cover property (take && !st_r.sync2.rnw && ofs == DPR_OFS_RDBUF_TS
      && st_r.sync2.serial && st_r.sync2.proto_v2);
   COV_AP_REQ: cover property (ap_req ##[1:20] ap_rdata_valid);

endmodule : dpr_regmap

// ==== hdl/dpr_pkg.sv ====
package dpr_pkg;

   // register offsets, byte addresses formed from address bits 3:2
   localparam logic [3:0]  DPR_OFS_ID_ABORT  = 4'h0;  // id on read, abort on write
   localparam logic [3:0]  DPR_OFS_CTRL_BANK = 4'h4;  // banked by the bank select field
   localparam logic [3:0]  DPR_OFS_SEL_RETRY = 4'h8;  // selector on write, retry on read
   localparam logic [3:0]  DPR_OFS_RDBUF_TS  = 4'hc;  // read buffer / target selection

   // bank select values seen at the banked offset
   localparam logic [3:0]  DPR_BANK_CTRL     = 4'h0;
   localparam logic [3:0]  DPR_BANK_LINK     = 4'h1;
   localparam logic [3:0]  DPR_BANK_TGTID    = 4'h2;
   localparam logic [3:0]  DPR_BANK_PROTID   = 4'h3;
   localparam logic [3:0]  DPR_BANK_EVENT    = 4'h4;

   // abort register bit positions
   localparam int          DPR_AB_TRIG       = 0;     // abort_trigger_bit
   localparam int          DPR_AB_CMP_CLR    = 1;     // compare_flag_clear
   localparam int          DPR_AB_ERR_CLR    = 2;     // sticky_error_clear
   localparam int          DPR_AB_WDE_CLR    = 3;     // write_data_error_clear
   localparam int          DPR_AB_ORUN_CLR   = 4;     // overrun_flag_clear

   // control/status bit positions
   localparam int          DPR_CS_SYS_ACK    = 31;
   localparam int          DPR_CS_SYS_REQ    = 30;
   localparam int          DPR_CS_DBG_ACK    = 29;
   localparam int          DPR_CS_DBG_REQ    = 28;
   localparam int          DPR_CS_RST_ACK    = 27;
   localparam int          DPR_CS_RST_REQ    = 26;
   localparam int          DPR_CS_TRN_LSB    = 12;    // 12-bit transaction counter
   localparam int          DPR_CS_MASK_LSB   = 8;     // 4-bit lane mask
   localparam int          DPR_CS_WDERR      = 7;
   localparam int          DPR_CS_READOK     = 6;
   localparam int          DPR_CS_STKERR     = 5;
   localparam int          DPR_CS_STKCMP     = 4;
   localparam int          DPR_CS_MODE_LSB   = 2;     // 2-bit transfer mode
   localparam int          DPR_CS_STKORUN    = 1;
   localparam int          DPR_CS_ORUNDET    = 0;

   // bank and port selector fields
   localparam int          DPR_SEL_BANK_LSB  = 0;
   localparam int          DPR_SEL_AP_LSB    = 24;

   // reset values and fixed identity words (identity values are arbitrary)
   localparam logic [31:0] DPR_RST_WORD      = 32'h0000_0000;
   localparam logic [31:0] DPR_PORT_ID       = 32'h1234_5001;
   localparam logic [31:0] DPR_TARGET_ID     = 32'h0000_a5a1;
   localparam logic [31:0] DPR_PROTO_ID      = 32'h0000_0001;

   // link pins, straps and acknowledges, all sampled through two flops
   typedef struct packed {
      logic        lclk;      // link clock level
      logic        valid;     // access present at this link edge
      logic        is_ap;     // access targets an access port
      logic        rnw;       // one for read
      logic [1:0]  addr;      // address bits 3:2
      logic [31:0] wdata;     // write data
      logic        abort_ir;  // scan chain: abort instruction loaded
      logic        serial;    // one: serial-wire link, zero: scan chain
      logic        arch_v2;   // one: version 2 map, zero: version 1
      logic        proto_v2;  // serial-wire protocol version 2
      logic        sys_ack;   // system powerup acknowledge
      logic        dbg_ack;   // debug powerup acknowledge
      logic        rst_ack;   // debug reset acknowledge
   } dpr_pins_s;

   // whole state of the port register block
   typedef struct packed {
      dpr_pins_s   sync1;       // first synchroniser stage
      dpr_pins_s   sync2;       // second synchroniser stage
      logic        lclk_d;      // delayed link clock for edge finding
      logic [31:0] select;      // bank_port_selector
      logic        sys_req;
      logic        dbg_req;
      logic        rst_req;
      logic [11:0] trn_cnt;
      logic [3:0]  mask_lane;
      logic [1:0]  trn_mode;
      logic        orun_det;
      logic        sticky_orun;
      logic        wdata_err;
      logic        sticky_err;
      logic        sticky_cmp;
      logic        read_ok;
      logic [31:0] link_ctrl;   // link_control_reg
      logic [31:0] target_sel;  // target_selection_reg
      logic [31:0] read_buffer_reg;      // read_buffer_reg
      logic [31:0] retry;       // read_retry_reg
      logic        aborted;     // an access port was aborted
      logic [7:0]  aborted_ap;  // which one
      logic        resp_valid;
      logic        resp_wait;
      logic [31:0] rdata;
      logic        abort_pulse;
      logic        ap_req;
      logic        ap_rnw;
      logic [1:0]  ap_addr;
      logic [31:0] ap_wdata;
   } dpr_state_s;

endpackage : dpr_pkg

// ==== tb/dpr_probe.sv ====
`timescale 1ns/100ps
// debugger probe: drives one access per link clock rise, clock idle between frames
module dpr_probe (
   // bench clock
   input  wire logic        clock,
   // link pins toward the port
   output logic             link_clk,
   output logic             lk_valid,
   output logic             lk_is_ap,
   output logic             lk_rnw,
   output logic [1:0]       lk_addr,
   output logic [31:0]      lk_wdata
);
   // quiet link at time zero
   initial begin
      {link_clk, lk_valid, lk_is_ap, lk_rnw, lk_addr, lk_wdata} = '0;
   end
   // one frame: pins settle 4 clocks, link clock high 4 and low 4, then release
   task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a,
                       input logic [31:0] d);
      {lk_valid, lk_is_ap, lk_rnw, lk_addr, lk_wdata} <= {1'b1, ap, rnw, a, d};
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      repeat (4) @(posedge clock);
      link_clk <= 1'b0;
      repeat (4) @(posedge clock);
      // released data shows the inverse so stale values cannot pass
      {lk_valid, lk_wdata} <= {1'b0, ~d};
      @(posedge clock);
   endtask : xfer
endmodule : dpr_probe

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   import dpr_pkg::*;
   logic        clock, reset, link_clk, lk_valid, lk_is_ap, lk_rnw, got_wait;
   logic        cfg_serial, cfg_arch_v2, cfg_proto_v2, ap_reg_locked, ap_recovered;
   logic        sys_pwr_ack, dbg_pwr_ack, dbg_rst_ack, resp_valid, resp_wait, abort_pulse;
   logic [1:0]  lk_addr;
   logic [3:0]  evt, sticky_flags;       // evt: overrun, wdata, port error, compare
   logic [11:0] trn_cnt;
   logic [31:0] lk_wdata, event_status, resp_rdata, got_rd, target_sel, link_ctrl;
   int          bad_count, checked, ab_n;
   dpr_probe probe (.*);
   dpr_regmap DUT (.*, .lk_abort_ir(1'b0), .ap_rdata_valid(1'b0), .ap_rdata(32'h0),
      .ap_resp_ok(1'b1), .ap_done(1'b0), .evt_overrun(evt[3]), .evt_wdata_error(evt[2]),
      .evt_ap_error(evt[1]), .evt_cmp_mismatch(evt[0]), .ap_req(), .ap_req_rnw(),
      .ap_req_addr(), .ap_req_wdata(), .ap_sel(), .sys_pwr_req(), .dbg_pwr_req(),
      .dbg_rst_req());
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // one-cycle answers are caught here so tasks can judge them later
   always @(posedge clock) begin
      if (resp_valid === 1'b1) {got_rd, got_wait} <= {resp_rdata, resp_wait};
      if (abort_pulse === 1'b1) ab_n <= ab_n + 1;
   end
   // decode of fixed, banked, retry and target selection slots
   task automatic t_map;
      logic [31:0] e;
      probe.xfer(1'b0, 1'b1, 2'h0, 32'h0);
      `CHK("id", DPR_PORT_ID, got_rd)
      probe.xfer(1'b0, 1'b1, 2'h2, 32'h0);
      `CHK("retry", DPR_PORT_ID, got_rd)
      probe.xfer(1'b0, 1'b0, 2'h2, 32'h1);
      probe.xfer(1'b0, 1'b0, 2'h1, 32'ha5);
      `CHK("link_ctrl", 32'ha5, link_ctrl)
      for (logic [3:0] b = 4'h2; b <= 4'h5; b++) begin
         e = (b == 4'h2) ? DPR_TARGET_ID : (b == 4'h3) ? DPR_PROTO_ID
           : (b == 4'h4) ? event_status : 32'h0;
         probe.xfer(1'b0, 1'b0, 2'h2, {28'h0, b});
         probe.xfer(1'b0, 1'b1, 2'h1, 32'h0);
         `CHK("bank", e, got_rd)
      end
      probe.xfer(1'b0, 1'b0, 2'h3, 32'h1122_3344);
      cfg_proto_v2 <= 1'b0;
      probe.xfer(1'b0, 1'b0, 2'h3, 32'h5);
      `CHK("target_sel", 32'h1122_3344, target_sel)
      cfg_serial <= 1'b0;
      probe.xfer(1'b0, 1'b1, 2'h2, 32'h0);
      `CHK("scan_retry", 32'h0, got_rd)
      {cfg_serial, cfg_proto_v2} <= 2'b11;
   endtask : t_map
   // sticky flags, their clears, the trigger and the aborted port
   task automatic t_abort;
      int n;
      probe.xfer(1'b0, 1'b0, 2'h2, 32'h0);
      probe.xfer(1'b0, 1'b0, 2'h1, 32'h1);
      evt <= 4'hf;
      @(posedge clock);
      evt <= 4'h0;
      n = ab_n;
      probe.xfer(1'b0, 1'b0, 2'h0, 32'h1);
      `CHK("pulse", n + 1, ab_n)
      `CHK("kept", 4'hf, sticky_flags)
      `CHK("trn_cnt", 12'h0, trn_cnt)
      for (int i = 0; i < 4; i++) begin
         probe.xfer(1'b0, 1'b0, 2'h0, 32'h10 >> i);
         `CHK("clear", 4'hf >> (i + 1), sticky_flags)
      end
      ap_reg_locked <= 1'b1;
      probe.xfer(1'b1, 1'b1, 2'h1, 32'h0);
      `CHK("wait", 1'b1, got_wait)
      ap_reg_locked <= 1'b0;
      probe.xfer(1'b1, 1'b1, 2'h1, 32'h0);
      `CHK("raz", 33'h0, {got_wait, got_rd})
      probe.xfer(1'b0, 1'b1, 2'h0, 32'h0);
      `CHK("no_readback", DPR_PORT_ID, got_rd)
   endtask : t_abort
   // verdict and end of run
   task automatic end_sim;
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   // main sequence: serial link, version 2 map, protocol 2
   initial begin
      {reset, cfg_serial, cfg_arch_v2, cfg_proto_v2, ap_reg_locked, ap_recovered} = 6'h3c;
      {sys_pwr_ack, dbg_pwr_ack, dbg_rst_ack, evt, got_wait, got_rd} = '0;
      event_status = 32'h5a5a_0f0f;
      {bad_count, checked, ab_n} = '0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      t_map;
      t_abort;
      end_sim;
   end
   // watchdog well beyond the ~350 clocks the run needs
   initial begin
      #100us;
      bad_count++;
      end_sim;
   end
endmodule : tb_top
